//--- src/ctm_select.sv
// chip test mode select: test register, mode decode, upper address mux,
// fifo fill path and pad test controls
// assumes io strobes arrive on clk; pins (ready, reset, pad strings) are async
`timescale 1ns/1ps

module ctm_select #(
    parameter int FIFO_AW = 5
) (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    power_on_reset,
    input  wire logic                    host_bus_reset_in,
    input  wire logic                    bus_ready_in,
    input  wire ctm_pkg::ctm_io_t        io,
    output logic [7:0]                   io_rdata,
    output logic                         io_rvalid,
    input  wire logic [7:0]              internal_source_bus,
    input  wire logic [7:0]              mem_address_hi,
    input  wire logic                    bus_master_state,
    input  wire logic [7:0]              internal_test_signals,
    input  wire logic [7:0]              pad_and_strings,
    input  wire logic                    fifo_port_write_enable,
    input  wire logic                    fifo_port_wr,
    input  wire logic                    fifo_port_rd,
    input  wire logic [31:0]             fifo_read_word,
    output logic [7:0]                   fifo_read_byte,
    output ctm_pkg::ctm_fifo_wr_t        fifo_wr,
    output logic [FIFO_AW-1:0]           fifo_write_pointer,
    output logic                         illegal_address_error,
    output logic [7:0]                   upper_address_outputs,
    output logic                         upper_address_oe,
    output logic                         all_pads_force_high,
    output logic                         all_pads_force_low,
    output ctm_pkg::ctm_mode_t           mode,
    output logic [2:0]                   subtest_code,
    output logic [7:0]                   host_subtest_decode
);
    import ctm_pkg::*;

    // ********************************
    // pin synchronisers
    // ********************************
    logic [2:0] sync_a;
    logic [2:0] sync_b;
    logic [7:0] str_a;
    logic [7:0] str_b;
    logic       ready_d;

    always_ff @(posedge clk) begin
        sync_a <= {power_on_reset, host_bus_reset_in, bus_ready_in};
        sync_b <= sync_a;
        str_a  <= pad_and_strings;
        str_b  <= str_a;
    end

    wire ready_s  = sync_b[0];
    wire hreset_s = sync_b[1];
    wire por_s    = sync_b[2];
    wire ready_rise = ready_s & ~ready_d;

    // ********************************
    // test select register
    // ********************************
    logic [7:0] test_select;
    logic       pad_high_armed;
    logic       pad_low_armed;

    wire sel_wr   = io.wr && (io.addr == TEST_SELECT_ADDR);
    wire sel_rd   = io.rd && (io.addr == TEST_SELECT_ADDR);
    wire [2:0] sub = test_select[SUB_MSB:SUB_LSB];
    wire host_on  = test_select[BIT_HOST];
    wire inpad_on = host_on && (sub == CTM_HT_INPAD);
    // pad test survives a bus reset until the tester drops ready
    wire clear_req = por_s || (hreset_s && !(inpad_on && ready_s));   // [R1] [R19] [R2]

    // host test only arms when ready is low; target test only when high
    wire [7:0] wr_value = {io.wdata[7:4],
                           io.wdata[BIT_HOST] & ~ready_s,                // [R6] [R23]
                           io.wdata[2:1],
                           io.wdata[BIT_TARGET] & ready_s};              // [R15]

    wire [7:0] next_test_select = clear_req ? TEST_SELECT_RST :
                                  sel_wr    ? wr_value : test_select;   // [R20] [R25]

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            test_select <= TEST_SELECT_RST;
            // ready idles high; a low reset value would fake a rise
            ready_d     <= 1'b1;
        end else begin
            test_select <= next_test_select;                            // [R1]
            ready_d     <= ready_s;
        end
    end

    // ********************************
    // output pad force modes
    // ********************************
    // pads start driving at the first ready rise after the write; a bus
    // reset or a test select write leaves, io writes are not expected meanwhile
    wire pad_high_sel = host_on && (sub == CTM_HT_PAD_HIGH);
    wire pad_low_sel  = host_on && (sub == CTM_HT_PAD_LOW);

    always_ff @(posedge clk) begin
        if (!rst_n || clear_req || sel_wr) begin
            pad_high_armed <= 1'b0;
            pad_low_armed  <= 1'b0;
        end else begin
            if (pad_high_sel && ready_rise) pad_high_armed <= 1'b1;     // [R21] [R22]
            if (pad_low_sel && ready_rise)  pad_low_armed  <= 1'b1;
        end
    end

    assign all_pads_force_high = pad_high_armed;                       // [R21]
    assign all_pads_force_low  = pad_low_armed;

    // ********************************
    // mode decode
    // ********************************
    function automatic logic one_hot5(input logic [4:0] v);
        one_hot5 = (v != 5'h00) && ((v & (v - 5'h01)) == 5'h00);
    endfunction

    function automatic logic [1:0] code_class(input logic [7:0] c);
        // bit 1 known, bit 0 monitor enabled
        case (c)
            8'h00, 8'h02, 8'h04, 8'h10, 8'h12,
            8'h14, 8'hd4, 8'hf4:                  code_class = 2'b10;   // [R16]
            8'h08, 8'h0c, 8'h18, 8'h1a, 8'h1c,
            8'h29, 8'h2b, 8'h2c, 8'h49, 8'h69,
            8'h88, 8'ha8, 8'hdc, 8'hfc:           code_class = 2'b11;   // [R17]
            default:                              code_class = 2'b00;
        endcase
    endfunction

    wire [1:0] cls       = code_class(test_select);
    wire       sub_valid = one_hot5(test_select[4:0]) || host_on;       // [R4]
    wire       illegal_mon = (test_select == CODE_ILLEGAL_MON);

    assign subtest_code = sub_valid ? sub : 3'h0;                        // [R4]

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_dec
            assign host_subtest_decode[g] = host_on && (sub == 3'(g)); // [R7]
        end
    endgenerate

    always_comb begin
        mode.ram_stress_enable         = test_select[BIT_RAM];          // [R5]
        mode.host_test_enable          = host_on;
        mode.sequencer_test_enable     = test_select[BIT_SEQ];          // [R11]
        mode.fifo_fill_test_enable     = test_select[BIT_FIFO];
        mode.target_bus_test_enable    = test_select[BIT_TARGET];       // [R15]
        mode.cycle_start_interlock_off = host_on && (sub != CTM_HT_MONITOR); // [R8]
        mode.error_hold                = illegal_mon;                   // [R24]
        mode.pause_inhibit             = illegal_mon;                   // [R24]
        mode.code_known                = cls[1];
        mode.monitor_code              = cls[0];
    end

    // ********************************
    // upper address outputs
    // ********************************
    // pad strings are already and-reduced outside; the reset pin's own
    // string input is held high during pad test until ready drops
    wire [7:0] strings = {str_b[7] | (hreset_s & ready_s), str_b[6:0]}; // [R18] [R19]
    logic [7:0] next_upper;

    always_comb begin
        if (!host_on) begin
            next_upper = mem_address_hi;                                 // [R9]
        end else if (sub == CTM_HT_MONITOR) begin
            next_upper = internal_source_bus;                            // [R10]
        end else if (sub == CTM_HT_INPAD && test_select != CODE_OSCILLATOR) begin
            next_upper = strings;                                        // [R18]
        end else if (pad_high_armed) begin
            next_upper = 8'hff;                                          // [R21]
        end else if (pad_low_armed) begin
            next_upper = 8'h00;
        end else begin
            next_upper = internal_test_signals;                          // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            upper_address_outputs <= 8'h00;
            upper_address_oe      <= 1'b0;
        end else begin
            upper_address_outputs <= next_upper;
            upper_address_oe      <= host_on ? 1'b1 : bus_master_state;  // [R9] [R21]
        end
    end

    // ********************************
    // fifo fill path
    // ********************************
    wire fill_hit = fifo_port_wr && fifo_port_write_enable && test_select[BIT_FIFO];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fifo_write_pointer    <= '0;
            fifo_wr               <= '0;
            illegal_address_error <= 1'b0;
            fifo_read_byte        <= 8'h00;
        end else begin
            fifo_wr.we      <= fill_hit;
            fifo_wr.data    <= {4{internal_source_bus}};                 // [R12]
            fifo_wr.byte_en <= {4{fill_hit}};
            if (fill_hit) fifo_write_pointer <= fifo_write_pointer + 1'b1; // [R12]
            // error register is held clear during illegal address monitor
            if (illegal_mon) illegal_address_error <= 1'b0;              // [R24]
            else if (fifo_port_wr && !fifo_port_write_enable)
                illegal_address_error <= 1'b1;                           // [R13]
            if (fifo_port_rd)
                fifo_read_byte <= fifo_read_word[8*fifo_write_pointer[1:0] +: 8]; // [R14]
        end
    end

    // ********************************
    // register read
    // ********************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            io_rdata  <= 8'h00;
            io_rvalid <= 1'b0;
        end else begin
            io_rvalid <= sel_rd;
            io_rdata  <= sel_rd ? test_select : 8'h00;                   // [R25]
        end
    end

endmodule // ctm_select

//--- src/ctm_pkg.sv
// constants, carrier types and mode codes for the chip test mode select block
// assumes one 250 MHz clock; pins are synchronised inside the top module
//
// Function
// [R1] reset clears register except during pad test
// [R2] tester holds ready low to clear pad test
// [R3] software avoids writing register in normal use
// [R4] sub-test code meaningful with one major bit
// [R5] bit 4 enables RAM stress in all RAMs
// [R6] host test needs ready low at write
// [R7] decode sub-test code into eight host tests
// [R8] codes 1-7 redirect address pins, drop interlock
// [R9] test off: pins carry address 23:16 when mastering
// [R10] code 0 mirrors source bus onto pins
// [R11] bit 2 puts sequencer into test mode
// [R12] fifo test: byte fills whole word, pointer increments
// [R13] fifo port write while disabled flags illegal address
// [R14] fifo port reads stay one byte wide
// [R15] target bus test needs ready high at write
// [R16] recognise non-monitor test codes
// [R17] recognise monitor-enabled test codes
// [R18] pad AND strings drive upper address pins
// [R19] pad test: reset ignored until ready low
// [R20] pad test left by write or reset
// [R21] pads high test drives all pads at ready rise
// [R22] tester runs no I/O in pads high test
// [R23] write with ready high clears host test
// [R24] illegal monitor holds error register, no pause
// [R25] register reads back last written value; code returns it with bit 3 and bit 0 gated by ready at the write
package ctm_pkg;

    // ********************************
    // register map
    // ********************************
    localparam logic [7:0] TEST_SELECT_ADDR = 8'h9f;
    localparam logic [7:0] TEST_SELECT_RST  = 8'h00;

    localparam int BIT_TARGET = 0;
    localparam int BIT_FIFO   = 1;
    localparam int BIT_SEQ    = 2;
    localparam int BIT_HOST   = 3;
    localparam int BIT_RAM    = 4;
    localparam int SUB_LSB    = 5;
    localparam int SUB_MSB    = 7;

    // ********************************
    // host sub-tests
    // ********************************
    typedef enum logic [2:0] {
        CTM_HT_MONITOR  = 3'h0,
        CTM_HT_INPAD    = 3'h1,
        CTM_HT_PAD_HIGH = 3'h2,
        CTM_HT_PAD_LOW  = 3'h3,
        CTM_HT_COUNT    = 3'h4,
        CTM_HT_ADDR     = 3'h5,
        CTM_HT_PARITY   = 3'h6,
        CTM_HT_RAMDATA  = 3'h7
    } ctm_subtest_t;

    // illegal address monitor shares code 1 with bit 2 set (value 2c)
    localparam logic [7:0] CODE_ILLEGAL_MON = 8'h2c;
    localparam logic [7:0] CODE_OSCILLATOR  = 8'h2b;

    // ********************************
    // carriers
    // ********************************
    typedef struct packed {
        logic       wr;      // one-cycle write strobe
        logic       rd;      // one-cycle read strobe
        logic [7:0] addr;
        logic [7:0] wdata;
    } ctm_io_t;

    typedef struct packed {
        logic ram_stress_enable;
        logic host_test_enable;
        logic sequencer_test_enable;
        logic fifo_fill_test_enable;
        logic target_bus_test_enable;
        logic cycle_start_interlock_off;
        logic error_hold;
        logic pause_inhibit;
        logic code_known;
        logic monitor_code;
    } ctm_mode_t;

    typedef struct packed {
        logic        we;
        logic [31:0] data;
        logic [3:0]  byte_en;
    } ctm_fifo_wr_t;

endpackage : ctm_pkg

//--- tb/ctm_select_checker.sv
// assertions for the chip test mode select block
// assumes a bind onto ctm_select and reads its ports only
`timescale 1ns/1ps

module ctm_select_checker
    import ctm_pkg::*;
#(
    parameter int FIFO_AW = 5
) (
    input wire logic                  clk,
    input wire logic                  rst_n,
    input wire ctm_pkg::ctm_io_t      io,
    input wire logic                  io_rvalid,
    input wire logic [7:0]            internal_source_bus,
    input wire logic [7:0]            mem_address_hi,
    input wire logic                  bus_master_state,
    input wire logic                  fifo_port_write_enable,
    input wire logic                  fifo_port_wr,
    input wire ctm_pkg::ctm_fifo_wr_t fifo_wr,
    input wire logic [FIFO_AW-1:0]    fifo_write_pointer,
    input wire logic                  illegal_address_error,
    input wire logic [7:0]            upper_address_outputs,
    input wire logic                  upper_address_oe,
    input wire ctm_pkg::ctm_mode_t    mode,
    input wire logic [2:0]            subtest_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ****************************
    // sequences
    // ****************************
    sequence s_read;
        io.rd && io.addr == TEST_SELECT_ADDR;
    endsequence
    sequence s_fill;
        fifo_port_wr && fifo_port_write_enable && mode.fifo_fill_test_enable;
    endsequence

    // ****************************
    // properties
    // ****************************
    read_answer_a: assert property (s_read |=> io_rvalid)
        else $error("register read not answered");
    answer_cause_a: assert property (io_rvalid |-> $past(io.rd) && $past(io.addr) == TEST_SELECT_ADDR)
        else $error("read answer without a read");
    fill_word_a: assert property (s_fill |=> fifo_wr.we && fifo_wr.data == {4{$past(internal_source_bus)}})
        else $error("fifo fill word wrong");
    fill_step_a: assert property (s_fill |=> fifo_write_pointer == $past(fifo_write_pointer) + 1'b1)
        else $error("fifo pointer did not step");
    illegal_write_a: assert property (fifo_port_wr && !fifo_port_write_enable && !mode.error_hold |=>
        illegal_address_error) else $error("illegal fifo write not flagged");
    error_hold_a: assert property (mode.error_hold |=> !illegal_address_error)
        else $error("error not held clear");
    sub_meaning_a: assert property (subtest_code != 3'h0 |-> mode.host_test_enable ||
        $onehot({mode.ram_stress_enable, mode.sequencer_test_enable, mode.fifo_fill_test_enable,
        mode.target_bus_test_enable})) else $error("sub-test code without one major bit");
    interlock_off_a: assert property (mode.host_test_enable && subtest_code != 3'h0 |->
        mode.cycle_start_interlock_off) else $error("interlock kept in host test");
    bus_mirror_a: assert property (mode.host_test_enable && subtest_code == 3'h0 |=> upper_address_oe &&
        upper_address_outputs == $past(internal_source_bus)) else $error("source bus not mirrored");
    normal_addr_a: assert property (!mode.host_test_enable && bus_master_state |=>
        upper_address_outputs == $past(mem_address_hi)) else $error("address not on upper pins");
endmodule // ctm_select_checker

bind ctm_select ctm_select_checker #(.FIFO_AW(FIFO_AW)) u_checker (
    .clk, .rst_n, .io, .io_rvalid, .internal_source_bus, .mem_address_hi, .bus_master_state,
    .fifo_port_write_enable, .fifo_port_wr, .fifo_wr, .fifo_write_pointer, .illegal_address_error,
    .upper_address_outputs, .upper_address_oe, .mode, .subtest_code
);

//--- tb/ctm_tester.sv
// part tester model: io bus cycles plus ready and bus reset pins
// assumes the block answers reads one cycle after the strobe
`timescale 1ns/1ps

module ctm_tester (
    input  wire logic        clk,
    input  wire logic [7:0]  io_rdata,
    input  wire logic        io_rvalid,
    output ctm_pkg::ctm_io_t io,
    output logic             bus_ready_in,
    output logic             host_bus_reset_in
);
    import ctm_pkg::*;

    initial begin
        io = '0;
        bus_ready_in = 1'b1;
        host_bus_reset_in = 1'b0;
    end

    // the level at a write decides which enable bit sticks
    task automatic pins(input logic ready, input logic rst);
        @(posedge clk);
        #1 bus_ready_in = ready;
        host_bus_reset_in = rst;
        repeat (5) @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        #1 io = '{1'b1, 1'b0, a, v};
        @(posedge clk);
        #1 io = '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        #1 io = '{1'b0, 1'b1, a, 8'h00};
        @(posedge clk);
        #1 io = '0;
        v = io_rvalid ? io_rdata : 8'hxx;
    endtask
endmodule // ctm_tester

//--- tb/chip_test_mode_select_bench.sv
// self-checking bench for the chip test mode select block
// assumes ctm_tester plays the part tester on the io bus and pins
`timescale 1ns/1ps

module chip_test_mode_select_bench;
    import ctm_pkg::*;

    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [7:0]   internal_source_bus = 8'h5a;
    logic [7:0]   mem_address_hi = 8'ha5;
    logic         bus_master_state = 1'b1;
    logic [7:0]   pad_and_strings = 8'h3c;
    logic         fifo_port_write_enable = 1'b0;
    logic         fifo_port_wr = 1'b0;
    ctm_io_t      io;
    logic         bus_ready_in;
    logic         host_bus_reset_in;
    logic [7:0]   io_rdata;
    logic         io_rvalid;
    ctm_fifo_wr_t fifo_wr;
    logic [4:0]   fifo_write_pointer;
    logic         illegal_address_error;
    logic [7:0]   upper_address_outputs;
    logic         upper_address_oe;
    logic         all_pads_force_high;
    logic         all_pads_force_low;
    logic [7:0]   host_subtest_decode;
    ctm_mode_t    mode;
    logic [2:0]   subtest_code;
    logic [7:0]   d;
    int           bad_count = 0;
    int           checks = 0;
    int           cycles = 0;
    localparam logic [7:0] PLAIN [8] = '{8'h00, 8'h02, 8'h04, 8'h10, 8'h12, 8'h14, 8'hd4, 8'hf4};
    localparam logic [7:0] MON [14] = '{8'h08, 8'h0c, 8'h18, 8'h1a, 8'h1c, 8'h29, 8'h2b, 8'h2c, 8'h49,
        8'h69, 8'h88, 8'ha8, 8'hdc, 8'hfc};

    always #2 clk = ~clk;

    ctm_tester u_tst (.clk, .io_rdata, .io_rvalid, .io, .bus_ready_in, .host_bus_reset_in);

    ctm_select #(.FIFO_AW(5)) u_dut (
        .clk, .rst_n, .power_on_reset(1'b0), .host_bus_reset_in, .bus_ready_in, .io, .io_rdata, .io_rvalid,
        .internal_source_bus, .mem_address_hi, .bus_master_state, .internal_test_signals(8'h00),
        .pad_and_strings, .fifo_port_write_enable, .fifo_port_wr, .fifo_port_rd(1'b0),
        .fifo_read_word(32'h0), .fifo_read_byte(), .fifo_wr, .fifo_write_pointer, .illegal_address_error,
        .upper_address_outputs, .upper_address_oe, .all_pads_force_high, .all_pads_force_low, .mode,
        .subtest_code, .host_subtest_decode
    );

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr_rd(input logic [7:0] v);
        u_tst.wr(TEST_SELECT_ADDR, v);
        u_tst.rd(TEST_SELECT_ADDR, d);
    endtask

    task automatic fifo_write();
        @(posedge clk);
        #1 fifo_port_wr = 1'b1;
        @(posedge clk);
        #1 fifo_port_wr = 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // hang guard, far above the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        #1 rst_n = 1'b1;
        u_tst.rd(TEST_SELECT_ADDR, d);
        chk("reset value", d, 8'h00);
        foreach (PLAIN[i]) begin
            wr_rd(PLAIN[i]);
            chk("plain code", d, PLAIN[i]);
            chk("ram stress", mode.ram_stress_enable, PLAIN[i][4]);
            chk("sequencer test", mode.sequencer_test_enable, PLAIN[i][2]);
        end
        $display("plain codes done");
        u_tst.pins(1'b0, 1'b0);
        foreach (MON[i]) begin
            wr_rd(MON[i]);
            chk("monitor code", d, MON[i] & 8'hfe);
            chk("host test", mode.host_test_enable, 1'b1);
            chk("sub-test", subtest_code, MON[i][7:5]);
            chk("sub-test decode", host_subtest_decode, 8'h01 << MON[i][7:5]);
            chk("interlock off", mode.cycle_start_interlock_off, MON[i][7:5] != 3'h0);
            if (MON[i][7:5] == 3'h0) begin
                chk("mirror", upper_address_outputs, internal_source_bus);
                chk("mirror enable", upper_address_oe, 1'b1);
            end
            if (MON[i] == 8'h29)
                chk("pad strings", upper_address_outputs, pad_and_strings);
        end
        $display("monitor codes done");
        u_tst.pins(1'b1, 1'b0);
        wr_rd(8'h09);
        chk("ready high write", d, 8'h01);
        u_tst.pins(1'b0, 1'b0);
        wr_rd(8'h29);
        u_tst.pins(1'b1, 1'b1);
        u_tst.rd(TEST_SELECT_ADDR, d);
        chk("pad test kept", d, 8'h28);
        u_tst.pins(1'b0, 1'b1);
        u_tst.rd(TEST_SELECT_ADDR, d);
        chk("pad test cleared", d, 8'h00);
        u_tst.pins(1'b1, 1'b0);
        chk("normal address", upper_address_outputs, mem_address_hi);
        chk("normal enable", upper_address_oe, 1'b1);
        $display("reset rules done");
        u_tst.wr(TEST_SELECT_ADDR, 8'h02);
        fifo_port_write_enable = 1'b1;
        internal_source_bus = 8'h3c;
        fifo_write();
        chk("fill word", {fifo_wr.we, fifo_wr.data}, {1'b1, 32'h3c3c3c3c});
        chk("fill pointer", fifo_write_pointer, 5'h01);
        fifo_port_write_enable = 1'b0;
        fifo_write();
        @(posedge clk);
        #1 chk("illegal address", illegal_address_error, 1'b1);
        $display("fifo test done");
        u_tst.pins(1'b0, 1'b0);
        u_tst.wr(TEST_SELECT_ADDR, 8'h49);
        u_tst.pins(1'b1, 1'b0);
        chk("pads high", all_pads_force_high, 1'b1);
        u_tst.pins(1'b1, 1'b1);
        u_tst.pins(1'b1, 1'b0);
        chk("pads released", all_pads_force_high, 1'b0);
        u_tst.pins(1'b0, 1'b0);
        u_tst.wr(TEST_SELECT_ADDR, 8'h69);
        u_tst.pins(1'b1, 1'b0);
        chk("pads low", all_pads_force_low, 1'b1);
        chk("pads low address", upper_address_outputs, 8'h00);
        u_tst.pins(1'b1, 1'b1);
        u_tst.pins(1'b1, 1'b0);
        chk("pads low released", all_pads_force_low, 1'b0);
        $display("pad output test done");
        tally_and_finish();
    end
endmodule // chip_test_mode_select_bench
